//--- hw/acr_pkg.sv
package acr_pkg;

  // register bus
  localparam int ACR_ADDR_WIDTH = 8;
  localparam int ACR_DATA_WIDTH = 8;

  // register offsets
  localparam logic [7:0] ACR_OFF_RESULT_LOW  = 8'h78;
  localparam logic [7:0] ACR_OFF_RESULT_HIGH = 8'h79;
  localparam logic [7:0] ACR_OFF_CONTROL     = 8'h7a;
  localparam logic [7:0] ACR_OFF_TRIGGER     = 8'h7b;
  localparam logic [7:0] ACR_OFF_INPUT_REF   = 8'h7c;
  localparam logic [7:0] ACR_OFF_IRQ_STATUS  = 8'h7d;
  localparam logic [7:0] ACR_OFF_IRQ_MASK    = 8'h7e;

  // conversion_control_status fields
  localparam int ACR_CSR_ENABLE_BIT = 7;
  localparam int ACR_CSR_START_BIT  = 6;
  localparam int ACR_CSR_AUTO_BIT   = 5;
  localparam int ACR_CSR_DONE_BIT   = 4;
  localparam int ACR_CSR_IRQEN_BIT  = 3;
  localparam int ACR_CSR_PRESC_LSB  = 0;

  // input_reference_select fields
  localparam int ACR_INSEL_REF_LSB  = 6;
  localparam int ACR_INSEL_LADJ_BIT = 5;
  localparam int ACR_INSEL_CHAN_LSB = 0;

  // reference codes
  localparam logic [1:0] ACR_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ACR_REF_SUPPLY   = 2'h1;
  localparam logic [1:0] ACR_REF_BANDGAP  = 2'h3;

  // channel codes
  localparam logic [4:0] ACR_CHAN_BANDGAP = 5'h1e;
  localparam logic [4:0] ACR_CHAN_GROUND  = 5'h1f;

  // trigger sources
  localparam logic [2:0] ACR_TRIG_FREE_RUNNING = 3'h0;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] ACR_LEN_FIRST  = 5'h19;
  localparam logic [4:0] ACR_LEN_NORMAL = 5'h0d;

  // interrupt status bits
  localparam int ACR_IRQ_WIDTH       = 3;
  localparam int ACR_IRQ_DONE_BIT    = 0;
  localparam int ACR_IRQ_ABORT_BIT   = 1;
  localparam int ACR_IRQ_OVERRUN_BIT = 2;

  // reset values
  localparam logic [7:0] ACR_RESET_BYTE = 8'h00;

  typedef enum logic {
    ACR_IDLE,
    ACR_CONVERT
  } acr_state_type;

endpackage

//--- hw/acr_control.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps

module acr_control (
  // clock and reset
  input  wire logic                                clock_in,
  input  wire logic                                rst_in,
  // register port
  input  wire logic [acr_pkg::ACR_ADDR_WIDTH-1:0]  addr_in,
  input  wire logic [acr_pkg::ACR_DATA_WIDTH-1:0]  wr_data_in,
  input  wire logic                                wr_en_in,
  input  wire logic                                rd_en_in,
  output logic      [acr_pkg::ACR_DATA_WIDTH-1:0]  rd_data_out,
  // cpu side
  input  wire logic                                global_irq_enable_in,
  input  wire logic                                vector_taken_in,
  output logic                                     conversion_irq_out,
  output logic                                     irq_out,
  // trigger events, bit 0 unused
  input  wire logic [7:0]                          trigger_events_in,
  // analog core
  input  wire logic                                core_done_in,
  input  wire logic [9:0]                          core_result_in,
  output logic                                     core_enable_out,
  output logic                                     sample_req_out,
  output logic                                     first_conversion_out,
  output logic                                     converter_tick_out,
  output logic                                     busy_out,
  output logic      [1:0]                          reference_out,
  output logic                                     ref_external_out,
  output logic                                     ref_supply_out,
  output logic                                     ref_bandgap_out,
  output logic      [4:0]                          channel_out,
  output logic                                     input_connected_out,
  output logic                                     differential_out,
  output logic      [2:0]                          positive_input_out,
  output logic      [2:0]                          negative_input_out,
  output logic                                     bandgap_input_out,
  output logic                                     ground_input_out
);
  import acr_pkg::*;

  typedef struct packed {
    acr_state_type                    state;
    logic                             enable;
    logic                             auto_trig;
    logic                             done_flag;
    logic                             irq_en;
    logic [2:0]                       presc;
    logic [2:0]                       trig_src;
    logic [1:0]                       ref_sw;
    logic                             left_adj;
    logic [4:0]                       chan_sw;
    logic [1:0]                       ref_act;
    logic [4:0]                       chan_act;
    logic                             first_pending;
    logic                             long_conv;
    logic [4:0]                       tick_count;
    logic [6:0]                       presc_cnt;
    logic                             tick;
    logic [9:0]                       result;
    logic [9:0]                       core_res;
    logic                             lock;
    logic                             trig_prev;
    logic [ACR_IRQ_WIDTH-1:0]         irq_status;
    logic [ACR_IRQ_WIDTH-1:0]         irq_mask;
    logic [7:0]                       rdata;
    logic                             sample_req;
  } acr_regs_type;

  acr_regs_type                       r;
  acr_regs_type                       next_r;

  ////////////////////////////////////////////////////////////////////////////

  // low bits of the free counter that must all be one for a tick
  function automatic logic [6:0] prescale_mask(input logic [2:0] code);
    unique case (code)
      3'h0, 3'h1: prescale_mask = 7'h01;
      3'h2:       prescale_mask = 7'h03;
      3'h3:       prescale_mask = 7'h07;
      3'h4:       prescale_mask = 7'h0f;
      3'h5:       prescale_mask = 7'h1f;
      3'h6:       prescale_mask = 7'h3f;
      3'h7:       prescale_mask = 7'h7f;
    endcase
  endfunction

  function automatic logic [7:0] present_low(input logic [9:0] res, input logic ladj);
    present_low = ladj ? {res[1:0], 6'h00} : res[7:0];
  endfunction

  function automatic logic [7:0] present_high(input logic [9:0] res, input logic ladj);
    present_high = ladj ? res[9:2] : {6'h00, res[9:8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic                               trig_sel;
  logic                               sw_start;
  logic                               complete;
  logic                               start;
  logic                               free_restart;
  logic [4:0]                         conv_len;
  logic [9:0]                         new_result;
  logic [ACR_IRQ_WIDTH-1:0]           events;

  always_comb begin
    next_r       = r;
    sw_start     = 1'b0;
    complete     = 1'b0;
    start        = 1'b0;
    events       = '0;
    next_r.sample_req = 1'b0;
    next_r.rdata      = ACR_RESET_BYTE;

    // free counter only runs while powered
    if (r.enable) begin
      next_r.presc_cnt = r.presc_cnt + 7'h01;
    end else begin
      next_r.presc_cnt = '0;
    end
    next_r.tick = r.enable &&
                  ((r.presc_cnt & prescale_mask(r.presc)) == prescale_mask(r.presc));

    // source 000 reads as low so selecting it never makes an edge
    trig_sel = (r.trig_src == ACR_TRIG_FREE_RUNNING) ? 1'b0
                                                     : trigger_events_in[r.trig_src];
    next_r.trig_prev = trig_sel;

    if (r.state == ACR_CONVERT && core_done_in) begin
      next_r.core_res = core_result_in;
    end

    // register writes
    if (wr_en_in) begin
      unique case (addr_in)
        ACR_OFF_CONTROL: begin
          next_r.enable    = wr_data_in[ACR_CSR_ENABLE_BIT];
          next_r.auto_trig = wr_data_in[ACR_CSR_AUTO_BIT];
          next_r.irq_en    = wr_data_in[ACR_CSR_IRQEN_BIT];
          next_r.presc     = wr_data_in[ACR_CSR_PRESC_LSB +: 3];
          sw_start         = wr_data_in[ACR_CSR_START_BIT];
          if (wr_data_in[ACR_CSR_DONE_BIT]) begin
            next_r.done_flag = 1'b0;
          end
        end
        ACR_OFF_TRIGGER: begin
          next_r.trig_src = wr_data_in[2:0];
        end
        ACR_OFF_INPUT_REF: begin
          next_r.ref_sw   = wr_data_in[ACR_INSEL_REF_LSB +: 2];
          next_r.left_adj = wr_data_in[ACR_INSEL_LADJ_BIT];
          next_r.chan_sw  = wr_data_in[ACR_INSEL_CHAN_LSB +: 5];
        end
        ACR_OFF_IRQ_MASK: begin
          next_r.irq_mask = wr_data_in[ACR_IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    if (vector_taken_in) begin
      next_r.done_flag = 1'b0;
    end

    // register reads, data one cycle later
    if (rd_en_in) begin
      unique case (addr_in)
        ACR_OFF_RESULT_LOW: begin
          next_r.rdata = present_low(r.result, r.left_adj);
          next_r.lock  = 1'b1;
        end
        ACR_OFF_RESULT_HIGH: begin
          next_r.rdata = present_high(r.result, r.left_adj);
          next_r.lock  = 1'b0;
        end
        ACR_OFF_CONTROL: begin
          next_r.rdata = {r.enable, r.state == ACR_CONVERT, r.auto_trig, r.done_flag,
                          r.irq_en, r.presc};
        end
        ACR_OFF_TRIGGER: begin
          next_r.rdata = {5'h00, r.trig_src};
        end
        ACR_OFF_INPUT_REF: begin
          next_r.rdata = {r.ref_sw, r.left_adj, r.chan_sw};
        end
        ACR_OFF_IRQ_STATUS: begin
          next_r.rdata      = {{(8-ACR_IRQ_WIDTH){1'b0}}, r.irq_status};
          next_r.irq_status = '0;
        end
        ACR_OFF_IRQ_MASK: begin
          next_r.rdata = {{(8-ACR_IRQ_WIDTH){1'b0}}, r.irq_mask};
        end
        default: begin
        end
      endcase
    end

    // power-up marks the next conversion as the long one
    if (next_r.enable && !r.enable) begin
      next_r.first_pending = 1'b1;
    end

    // running conversion
    conv_len   = r.long_conv ? ACR_LEN_FIRST : ACR_LEN_NORMAL;
    new_result = core_done_in ? core_result_in : r.core_res;
    if (r.state == ACR_CONVERT) begin
      if (!next_r.enable) begin
        next_r.state = ACR_IDLE;
        events[ACR_IRQ_ABORT_BIT] = 1'b1;
      end else if (r.tick) begin
        if (r.tick_count == conv_len - 5'h01) begin
          complete = 1'b1;
        end else begin
          next_r.tick_count = r.tick_count + 5'h01;
        end
      end
    end

    if (complete) begin
      // a frozen pair keeps the old result; the new one is lost
      if (!next_r.lock) begin
        next_r.result = new_result;
      end else begin
        events[ACR_IRQ_OVERRUN_BIT] = 1'b1;
      end
      next_r.done_flag = 1'b1;
      next_r.state     = ACR_IDLE;
      events[ACR_IRQ_DONE_BIT] = 1'b1;
    end

    // idle selections follow software at once
    if (next_r.state == ACR_IDLE) begin
      next_r.chan_act = next_r.chan_sw;
      next_r.ref_act  = next_r.ref_sw;
    end

    free_restart = complete && r.auto_trig && (r.trig_src == ACR_TRIG_FREE_RUNNING);
    start = next_r.enable && (next_r.state == ACR_IDLE) &&
            (sw_start || (r.auto_trig && trig_sel && !r.trig_prev) || free_restart);
    if (start) begin
      next_r.state         = ACR_CONVERT;
      next_r.long_conv     = next_r.first_pending;
      next_r.first_pending = 1'b0;
      next_r.tick_count    = '0;
      next_r.presc_cnt     = '0;
      next_r.tick          = 1'b0;
      next_r.sample_req    = 1'b1;
    end

    // set wins over the read clear
    next_r.irq_status = next_r.irq_status | events;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      r       <= '0;
      r.state <= ACR_IDLE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign rd_data_out          = r.rdata;
  assign conversion_irq_out   = r.done_flag && r.irq_en && global_irq_enable_in;
  assign irq_out              = |(r.irq_status & r.irq_mask);
  assign core_enable_out      = r.enable;
  assign sample_req_out       = r.sample_req;
  assign first_conversion_out = r.long_conv;
  assign converter_tick_out   = r.tick;
  assign busy_out             = (r.state == ACR_CONVERT);
  assign reference_out        = r.ref_act;
  assign channel_out          = r.chan_act;
  assign ref_external_out     = (r.ref_act == ACR_REF_EXTERNAL);
  assign ref_supply_out       = (r.ref_act == ACR_REF_SUPPLY);
  assign ref_bandgap_out      = (r.ref_act == ACR_REF_BANDGAP);

  // input multiplexer decode
  always_comb begin
    input_connected_out = 1'b1;
    differential_out    = 1'b0;
    positive_input_out  = r.chan_act[2:0];
    negative_input_out  = 3'h0;
    bandgap_input_out   = 1'b0;
    ground_input_out    = 1'b0;
    if (r.chan_act == ACR_CHAN_BANDGAP) begin
      bandgap_input_out = 1'b1;
    end else if (r.chan_act == ACR_CHAN_GROUND) begin
      ground_input_out = 1'b1;
    end else if (r.chan_act[4:3] == 2'h1) begin
      input_connected_out = 1'b0;
    end else if (r.chan_act[4:3] == 2'h2) begin
      differential_out   = 1'b1;
      negative_input_out = 3'h1;
    end else if (r.chan_act[4:3] == 2'h3) begin
      differential_out   = 1'b1;
      negative_input_out = 3'h2;
    end
  end

endmodule

//--- dv/acr_core_model.sv
`timescale 1ns/100ps
module acr_core_model (
  // clock
  input  wire logic       clock_in,
  // from control
  input  wire logic       sample_req_in,
  // bench settings
  input  wire logic [9:0] value_in,
  input  wire logic [3:0] delay_in,
  // to control
  output logic            core_done_out,
  output logic      [9:0] core_result_out
);
  logic [9:0] held     = 10'h000;
  logic [3:0] wait_cnt = 4'h0;
  logic       pending  = 1'b0;
  logic       fire     = 1'b0;
  // a new request restarts the count, so an aborted conversion never leaks its value
  // delay stays below 26 cycles, the shortest conversion
  always @(posedge clock_in) begin
    fire <= pending && !sample_req_in && (wait_cnt == 4'h0);
    if (sample_req_in) begin
      held     <= value_in;
      wait_cnt <= delay_in;
      pending  <= 1'b1;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else begin
      pending <= 1'b0;
    end
  end
  assign core_done_out   = fire;
  // bus not valid outside the strobe: show the inverse, never the stale value
  assign core_result_out = fire ? held : ~held;
endmodule

//--- dv/acr_control_chk.sv
`timescale 1ns/100ps
module acr_control_chk
  import acr_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       global_irq_enable_in,
  input wire logic       conversion_irq_out,
  input wire logic       core_enable_out,
  input wire logic       sample_req_out,
  input wire logic       first_conversion_out,
  input wire logic       converter_tick_out,
  input wire logic       busy_out,
  input wire logic [1:0] reference_out,
  input wire logic       ref_external_out,
  input wire logic       ref_supply_out,
  input wire logic       ref_bandgap_out,
  input wire logic [4:0] channel_out,
  input wire logic       input_connected_out,
  input wire logic       differential_out,
  input wire logic [2:0] positive_input_out,
  input wire logic [2:0] negative_input_out,
  input wire logic       bandgap_input_out,
  input wire logic       ground_input_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [7:0] tick_cnt;
  always_ff @(posedge clock_in) begin
    if (rst_in || sample_req_out) begin
      tick_cnt <= 8'h00;
    end else if (busy_out && converter_tick_out) begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
  sequence s_req;
    sample_req_out ##1 !sample_req_out;
  endsequence
  sequence s_finish;
    $fell(busy_out) ##0 core_enable_out;
  endsequence
  a_start_req: assert property ($rose(busy_out) |-> s_req)
    else $error("sample request missing at start");
  a_start_enabled: assert property ($rose(busy_out) |-> core_enable_out)
    else $error("conversion started while off");
  a_abort_idle: assert property (!core_enable_out |-> !busy_out)
    else $error("busy while converter off");
  a_conv_length: assert property (s_finish |->
    tick_cnt == {3'h0, first_conversion_out ? ACR_LEN_FIRST : ACR_LEN_NORMAL})
    else $error("conversion length wrong");
  a_ref_decode: assert property (ref_external_out == (reference_out == 2'h0)
    && ref_supply_out == (reference_out == 2'h1) && ref_bandgap_out == (reference_out == 2'h3))
    else $error("reference decode wrong");
  a_chan_single: assert property (channel_out[4:3] == 2'h0 |-> input_connected_out
    && !differential_out && positive_input_out == channel_out[2:0])
    else $error("single input decode wrong");
  a_chan_fixed: assert property (bandgap_input_out == (channel_out == ACR_CHAN_BANDGAP)
    && ground_input_out == (channel_out == ACR_CHAN_GROUND)
    && (channel_out[4:3] != 2'h1 || !input_connected_out))
    else $error("fixed input decode wrong");
  a_chan_diff: assert property (channel_out[4] && channel_out < 5'h1e |-> differential_out
    && positive_input_out == channel_out[2:0]
    && negative_input_out == (channel_out[3] ? 3'h2 : 3'h1))
    else $error("differential decode wrong");
  a_sel_held: assert property (busy_out && $past(busy_out) && !sample_req_out
    |-> $stable(channel_out) && $stable(reference_out))
    else $error("selection changed mid conversion");
  a_irq_gate: assert property (conversion_irq_out |-> global_irq_enable_in)
    else $error("irq without global enable");
endmodule
bind acr_control acr_control_chk u_chk (.clock_in, .rst_in, .global_irq_enable_in,
  .conversion_irq_out, .core_enable_out, .sample_req_out, .first_conversion_out,
  .converter_tick_out, .busy_out, .reference_out, .ref_external_out, .ref_supply_out,
  .ref_bandgap_out, .channel_out, .input_connected_out, .differential_out,
  .positive_input_out, .negative_input_out, .bandgap_input_out, .ground_input_out);

//--- dv/tb_acr_control.sv
`timescale 1ns/100ps
module tb_acr_control;
  import acr_pkg::*;
  logic       clock_in, rst_in, wr_en_in, rd_en_in, global_irq_enable_in, vector_taken_in;
  logic [7:0] addr_in, wr_data_in, rd_data_out, trigger_events_in;
  logic       core_done_in, conversion_irq_out, irq_out, busy_out, sample_req_out;
  logic [9:0] core_result_in, core_val;
  logic [3:0] core_dly;
  logic [4:0] channel_out;
  logic [1:0] reference_out;
  int         n_errors, check_count;
  acr_control DUT (.clock_in, .rst_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .global_irq_enable_in, .vector_taken_in, .conversion_irq_out, .irq_out,
    .trigger_events_in, .core_done_in, .core_result_in, .core_enable_out(),
    .sample_req_out, .first_conversion_out(), .converter_tick_out(), .busy_out,
    .reference_out, .ref_external_out(), .ref_supply_out(), .ref_bandgap_out(),
    .channel_out, .input_connected_out(), .differential_out(), .positive_input_out(),
    .negative_input_out(), .bandgap_input_out(), .ground_input_out());
  acr_core_model u_core (.clock_in, .sample_req_in(sample_req_out), .value_in(core_val),
    .delay_in(core_dly), .core_done_out(core_done_in), .core_result_out(core_result_in));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one idle cycle after each strobe keeps every driver edge single
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    @(posedge clock_in);
    d = rd_data_out;
  endtask
  task automatic wait_idle(output int k);
    k = 0;
    @(posedge clock_in);
    while (busy_out !== 1'b0 && k < 20000) begin
      @(posedge clock_in);
      k++;
    end
  endtask
  function automatic logic [15:0] present(input logic [9:0] r, input logic la);
    return la ? {r, 6'h00} : {6'h00, r};
  endfunction
  function automatic int div_of(input logic [2:0] ps);
    return (ps < 3'h2) ? 2 : (1 << ps);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock_in);
    n_errors++;
    report_and_stop();
  end
  initial begin
    logic [7:0] v, lo, hi;
    logic [15:0] w;
    logic [9:0] res;
    logic [2:0] ps;
    logic       la;
    int         k, t;
    {wr_en_in, rd_en_in, global_irq_enable_in, vector_taken_in} = 4'h0;
    {addr_in, wr_data_in, trigger_events_in} = 24'h00_0000;
    {core_val, core_dly} = 14'h0000;
    rst_in = 1'b1;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    void'($urandom(50));
    for (int a = 8'h78; a < 8'h80; a++) begin
      rd(a[7:0], v);
      chk("reset byte", 16'h0000, {8'h00, v});
    end
    for (int i = 0; i < 32; i++) begin
      wr(ACR_OFF_INPUT_REF, {i[1:0], 1'b0, i[4:0]});
      chk("channel", {11'h000, i[4:0]}, {11'h000, channel_out});
      chk("reference", {14'h0000, i[1:0]}, {14'h0000, reference_out});
    end
    wr(ACR_OFF_IRQ_MASK, 8'h01);
    for (int n = 0; n < 6; n++) begin
      res = 10'($urandom);
      ps = 3'($urandom);
      la = 1'($urandom);
      core_val <= res;
      core_dly <= 4'($urandom);
      global_irq_enable_in <= n[0];
      wr(ACR_OFF_INPUT_REF, {2'h1, la, 5'h03});
      wr(ACR_OFF_CONTROL, {5'h19, ps});
      wr(ACR_OFF_INPUT_REF, {2'h3, la, 5'h1f});
      chk("held channel", 16'h0003, {11'h000, channel_out});
      chk("held reference", 16'h0001, {14'h0000, reference_out});
      wait_idle(k);
      t = div_of(ps) * (n == 0 ? 25 : 13);
      chk("busy span", 16'h0001, {15'h0000, k + 6 >= t && k <= t + 2});
      chk("applied channel", 16'h001f, {11'h000, channel_out});
      chk("applied reference", 16'h0003, {14'h0000, reference_out});
      chk("irq", {15'h0000, n[0]}, {15'h0000, conversion_irq_out});
      chk("irq line", 16'h0001, {15'h0000, irq_out});
      wr(ACR_OFF_CONTROL, {5'h11, ps});
      rd(ACR_OFF_CONTROL, v);
      chk("control", {8'h00, 5'h13, ps}, {8'h00, v});
      rd(ACR_OFF_RESULT_LOW, lo);
      rd(ACR_OFF_RESULT_HIGH, hi);
      chk("result", present(res, la), {hi, lo});
      wr(ACR_OFF_INPUT_REF, {2'h3, ~la, 5'h1f});
      rd(ACR_OFF_RESULT_HIGH, hi);
      w = present(res, ~la);
      chk("readjusted", {8'h00, w[15:8]}, {8'h00, hi});
      rd(ACR_OFF_IRQ_STATUS, v);
      chk("status", 16'h0001, {8'h00, v});
      chk("irq line clear", 16'h0000, {15'h0000, irq_out});
      if (n[0]) begin
        vector_taken_in <= 1'b1;
        @(posedge clock_in);
        vector_taken_in <= 1'b0;
        @(posedge clock_in);
      end else begin
        wr(ACR_OFF_CONTROL, {5'h13, ps});
      end
      rd(ACR_OFF_CONTROL, v);
      chk("done cleared", {8'h00, 5'h11, ps}, {8'h00, v});
    end
    // abort while converting, then mask and unmask the abort status
    wr(ACR_OFF_CONTROL, 8'hc8);
    wr(ACR_OFF_CONTROL, 8'h08);
    chk("aborted", 16'h0000, {15'h0000, busy_out});
    chk("masked", 16'h0000, {15'h0000, irq_out});
    wr(ACR_OFF_IRQ_MASK, 8'h03);
    chk("unmasked", 16'h0001, {15'h0000, irq_out});
    rd(ACR_OFF_IRQ_STATUS, v);
    chk("abort status", 16'h0002, {8'h00, v});
    // low byte read freezes result across a later conversion
    res = 10'($urandom);
    core_val <= res;
    wr(ACR_OFF_INPUT_REF, 8'h43);
    wr(ACR_OFF_CONTROL, 8'hc8);
    wait_idle(k);
    rd(ACR_OFF_RESULT_LOW, lo);
    core_val <= ~res;
    wr(ACR_OFF_CONTROL, 8'hd8);
    wait_idle(k);
    rd(ACR_OFF_RESULT_HIGH, hi);
    chk("frozen", present(res, 1'b0), {hi, lo});
    rd(ACR_OFF_IRQ_STATUS, v);
    chk("overrun status", 16'h0005, {8'h00, v});
    // auto trigger on source 3; other bits and source 0 must not start
    wr(ACR_OFF_TRIGGER, 8'h03);
    wr(ACR_OFF_CONTROL, 8'hb8);
    trigger_events_in <= 8'h10;
    repeat (4) @(posedge clock_in);
    chk("wrong source", 16'h0000, {15'h0000, busy_out});
    trigger_events_in <= 8'h18;
    repeat (3) @(posedge clock_in);
    chk("triggered", 16'h0001, {15'h0000, busy_out});
    wait_idle(k);
    wr(ACR_OFF_TRIGGER, 8'h00);
    repeat (4) @(posedge clock_in);
    chk("free select", 16'h0000, {15'h0000, busy_out});
    // free running: one start, then restarts until auto trigger is cleared
    wr(ACR_OFF_CONTROL, 8'hf8);
    repeat (60) @(posedge clock_in);
    rd(ACR_OFF_CONTROL, v);
    chk("free running", 16'h00f8, {8'h00, v});
    wr(ACR_OFF_CONTROL, 8'h88);
    wait_idle(k);
    chk("free stop", 16'h0001, {15'h0000, k <= 30});
    report_and_stop();
  end
endmodule
